// *** hw/rtu_register_slave_decoder.sv ***
`timescale 1ns/1ps
module rtu_register_slave_decoder
  import rtu_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] node_addr_i,
  input wire logic addr_mode_i,
  input wire logic [15:0] max_read_regs_i,
  input wire logic [19:0] char_cycles_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic tx_two_stop_o,
  output logic par_req_o,
  output logic par_write_o,
  output logic [1:0] par_type_o,
  output logic [7:0] par_menu_o,
  output logic [7:0] par_param_o,
  output logic [15:0] par_wdata_o,
  input wire logic par_ack_i,
  input wire logic [31:0] par_rdata_i,
  output logic busy_o,
  output logic crc_err_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic frame_end;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic tx_take;
  logic tx_crc_clr;
  logic tx_crc_en;

  rtu_state_e state_reg, state_next;
  logic [7:0] rx_buf_reg [0:7];
  logic [7:0] rx_buf_next [0:7];
  logic [7:0] rx_cnt_reg, rx_cnt_next;
  logic rx_drop_reg, rx_drop_next;
  logic bcast_reg, bcast_next;
  logic is_write_reg, is_write_next;
  logic wide_reg, wide_next;
  logic [15:0] cur_raw_reg, cur_raw_next;
  logic [15:0] regs_left_reg, regs_left_next;
  logic [7:0] hdr_reg [0:5];
  logic [7:0] hdr_next [0:5];
  logic [2:0] hdr_len_reg, hdr_len_next;
  logic [2:0] pos_reg, pos_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic tx_valid_reg, tx_valid_next;
  logic two_stop_reg;
  logic par_req_reg, par_req_next;
  logic par_write_reg, par_write_next;
  logic [1:0] par_type_reg, par_type_next;
  logic [7:0] par_menu_reg, par_menu_next;
  logic [7:0] par_param_reg, par_param_next;
  logic [15:0] par_wdata_reg, par_wdata_next;
  logic busy_reg, busy_next;
  logic crc_err_reg, crc_err_next;

  ////////////////////////////////////////////////////////////////////////////
  rtu_gap_timer u_gap (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .rx_valid_i(rx_valid_i),
    .char_cycles_i(char_cycles_i),
    .frame_end_o(frame_end)
  );

  // the stop-bit count is the uart's business; the check runs on bytes only
  rtu_crc16 u_rx_crc (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .clr_i(frame_end),
    .en_i(rx_valid_i),
    .data_i(rx_data_i),
    .crc_o(rx_crc)
  );

  assign tx_take = tx_valid_reg & tx_ready_i;
  assign tx_crc_clr = (state_reg == S_DEC);
  // the check bytes themselves must not fold into the running value
  assign tx_crc_en = tx_take & (state_reg != S_CRCL) & (state_reg != S_CRCH);

  rtu_crc16 u_tx_crc (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .clr_i(tx_crc_clr),
    .en_i(tx_crc_en),
    .data_i(tx_data_reg),
    .crc_o(tx_crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rtu_map_s m;
    logic [15:0] n_regs;
    logic own_ok;
    logic [31:0] shifted;
    logic [2:0] sel;
    logic [15:0] step;
    m = rtu_map(16'h0000, 1'b0);
    n_regs = {rx_buf_reg[4], rx_buf_reg[5]};
    own_ok = (node_addr_i >= RTU_NODE_MIN) && (node_addr_i <= RTU_NODE_MAX);
    sel = wide_reg ? pos_reg : pos_reg + 3'h2;
    shifted = rdata_reg << {sel, 3'b000};
    step = wide_reg ? 16'h0002 : 16'h0001;

    state_next = state_reg;
    rx_buf_next = rx_buf_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_drop_next = rx_drop_reg;
    bcast_next = bcast_reg;
    is_write_next = is_write_reg;
    wide_next = wide_reg;
    cur_raw_next = cur_raw_reg;
    regs_left_next = regs_left_reg;
    hdr_next = hdr_reg;
    hdr_len_next = hdr_len_reg;
    pos_next = pos_reg;
    rdata_next = rdata_reg;
    tx_data_next = tx_data_reg;
    tx_valid_next = tx_valid_reg;
    par_req_next = par_req_reg;
    par_write_next = par_write_reg;
    par_type_next = par_type_reg;
    par_menu_next = par_menu_reg;
    par_param_next = par_param_reg;
    par_wdata_next = par_wdata_reg;
    busy_next = (state_reg != S_IDLE);
    crc_err_next = 1'b0;

    // receive side: half duplex, so bytes seen while busy spoil the frame
    if (rx_valid_i) begin
      if (state_reg != S_IDLE) begin
        rx_drop_next = 1'b1;
      end else begin
        if (rx_cnt_reg < RTU_REQ_LEN) begin
          rx_buf_next[rx_cnt_reg[2:0]] = rx_data_i;
        end
        if (rx_cnt_reg != 8'hff) begin
          rx_cnt_next = rx_cnt_reg + 8'h01;
        end
      end
    end

    case (state_reg)
      S_IDLE: begin
        if (frame_end) begin
          rx_cnt_next = 8'h00;
          rx_drop_next = 1'b0;
          bcast_next = (rx_buf_reg[0] == RTU_NODE_BCAST);
          if (rx_drop_reg || rx_cnt_reg < RTU_MIN_FRAME) begin
            state_next = S_IDLE;
          end else if (rx_crc != 16'h0000) begin
            crc_err_next = 1'b1;
          end else if (rx_buf_reg[0] == RTU_NODE_BCAST || (own_ok && rx_buf_reg[0] == node_addr_i)) begin
            state_next = S_DEC;
            rx_cnt_next = rx_cnt_reg;
          end
        end
      end
      S_DEC: begin
        m = rtu_map({rx_buf_reg[2], rx_buf_reg[3]}, addr_mode_i);
        cur_raw_next = {rx_buf_reg[2], rx_buf_reg[3]};
        wide_next = (m.dtype != RTU_TYPE_I16);
        hdr_next[0] = node_addr_i;
        hdr_next[1] = rx_buf_reg[1] | RTU_EXC_FLAG;
        hdr_next[2] = RTU_EXC_FUNC;
        hdr_len_next = RTU_HDR_SHORT;
        pos_next = 3'h0;
        rx_cnt_next = 8'h00;
        state_next = bcast_reg ? S_IDLE : S_HDR;
        case (rx_buf_reg[1])
          RTU_FC_READ: begin
            is_write_next = 1'b0;
            regs_left_next = n_regs;
            hdr_next[2] = RTU_EXC_ADDR;
            if (rx_cnt_reg != RTU_REQ_LEN) begin
              state_next = S_IDLE;
            end else if (n_regs == 16'h0000 || n_regs > max_read_regs_i || n_regs > RTU_RD_ABS_MAX ||
                         (m.dtype != RTU_TYPE_I16 && n_regs[0]) || !m.ok) begin
              state_next = bcast_reg ? S_IDLE : S_HDR;
            end else begin
              hdr_next[1] = RTU_FC_READ;
              hdr_next[2] = {n_regs[6:0], 1'b0};
            end
          end
          RTU_FC_WRITE: begin
            is_write_next = 1'b1;
            hdr_next[2] = RTU_EXC_ADDR;
            if (!m.ok) begin
              state_next = bcast_reg ? S_IDLE : S_HDR;
            end else begin
              state_next = S_REQ;
            end
          end
          RTU_FC_WMULT, RTU_FC_RWMULT: begin
            // RTU_FC_WMULT and RTU_FC_RWMULT frames are dropped without reply, whatever their length
            state_next = S_IDLE;
          end
          default: begin
            state_next = bcast_reg ? S_IDLE : S_HDR;
          end
        endcase
      end
      S_REQ: begin
        m = rtu_map(cur_raw_reg, addr_mode_i);
        par_req_next = 1'b1;
        par_write_next = is_write_reg;
        par_type_next = m.dtype;
        par_menu_next = m.menu;
        par_param_next = m.param;
        par_wdata_next = {rx_buf_reg[4], rx_buf_reg[5]};
        state_next = S_WAIT;
      end
      S_WAIT: begin
        if (par_ack_i) begin
          par_req_next = 1'b0;
          rdata_next = par_rdata_i;
          pos_next = 3'h0;
          if (!is_write_reg) begin
            state_next = S_DATA;
          end else if (bcast_reg) begin
            state_next = S_IDLE;
          end else begin
            for (int i = 1; i < 6; i++) begin
              hdr_next[i] = rx_buf_reg[i];
            end
            hdr_len_next = RTU_HDR_ECHO;
            state_next = S_HDR;
          end
        end
      end
      S_HDR: begin
        if (!tx_valid_reg) begin
          tx_data_next = hdr_reg[pos_reg];
          tx_valid_next = 1'b1;
        end else if (tx_ready_i) begin
          tx_valid_next = 1'b0;
          pos_next = pos_reg + 3'h1;
          if (pos_reg + 3'h1 == hdr_len_reg) begin
            pos_next = 3'h0;
            state_next = (!is_write_reg && hdr_reg[1] == RTU_FC_READ) ? S_REQ : S_CRCL;
          end
        end
      end
      S_DATA: begin
        if (!tx_valid_reg) begin
          tx_data_next = shifted[31:24];
          tx_valid_next = 1'b1;
        end else if (tx_ready_i) begin
          tx_valid_next = 1'b0;
          pos_next = pos_reg + 3'h1;
          if (pos_reg == (wide_reg ? 3'h3 : 3'h1)) begin
            pos_next = 3'h0;
            regs_left_next = regs_left_reg - step;
            cur_raw_next = cur_raw_reg + 16'h0001;
            state_next = (regs_left_reg == step) ? S_CRCL : S_REQ;
          end
        end
      end
      S_CRCL: begin
        if (!tx_valid_reg) begin
          tx_data_next = tx_crc[7:0];
          tx_valid_next = 1'b1;
        end else if (tx_ready_i) begin
          tx_valid_next = 1'b0;
          state_next = S_CRCH;
        end
      end
      S_CRCH: begin
        if (!tx_valid_reg) begin
          tx_data_next = tx_crc[15:8];
          tx_valid_next = 1'b1;
        end else if (tx_ready_i) begin
          tx_valid_next = 1'b0;
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      rx_buf_reg <= '{default: 8'h00};
      rx_cnt_reg <= 8'h00;
      rx_drop_reg <= 1'b0;
      bcast_reg <= 1'b0;
      is_write_reg <= 1'b0;
      wide_reg <= 1'b0;
      cur_raw_reg <= 16'h0000;
      regs_left_reg <= 16'h0000;
      hdr_reg <= '{default: 8'h00};
      hdr_len_reg <= 3'h0;
      pos_reg <= 3'h0;
      rdata_reg <= 32'h00000000;
      tx_data_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      two_stop_reg <= 1'b0;
      par_req_reg <= 1'b0;
      par_write_reg <= 1'b0;
      par_type_reg <= 2'h0;
      par_menu_reg <= 8'h00;
      par_param_reg <= 8'h00;
      par_wdata_reg <= 16'h0000;
      busy_reg <= 1'b0;
      crc_err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rx_buf_reg <= rx_buf_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_drop_reg <= rx_drop_next;
      bcast_reg <= bcast_next;
      is_write_reg <= is_write_next;
      wide_reg <= wide_next;
      cur_raw_reg <= cur_raw_next;
      regs_left_reg <= regs_left_next;
      hdr_reg <= hdr_next;
      hdr_len_reg <= hdr_len_next;
      pos_reg <= pos_next;
      rdata_reg <= rdata_next;
      tx_data_reg <= tx_data_next;
      tx_valid_reg <= tx_valid_next;
      two_stop_reg <= 1'b1;
      par_req_reg <= par_req_next;
      par_write_reg <= par_write_next;
      par_type_reg <= par_type_next;
      par_menu_reg <= par_menu_next;
      par_param_reg <= par_param_next;
      par_wdata_reg <= par_wdata_next;
      busy_reg <= busy_next;
      crc_err_reg <= crc_err_next;
    end
  end

  assign tx_data_o = tx_data_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_two_stop_o = two_stop_reg;
  assign par_req_o = par_req_reg;
  assign par_write_o = par_write_reg;
  assign par_type_o = par_type_reg;
  assign par_menu_o = par_menu_reg;
  assign par_param_o = par_param_reg;
  assign par_wdata_o = par_wdata_reg;
  assign busy_o = busy_reg;
  assign crc_err_o = crc_err_reg;

endmodule : rtu_register_slave_decoder

// *** hw/rtu_pkg.sv ***
package rtu_pkg;

  localparam logic [7:0] RTU_FC_READ = 8'h03;
  localparam logic [7:0] RTU_FC_WRITE = 8'h06;
  localparam logic [7:0] RTU_FC_WMULT = 8'h10;
  localparam logic [7:0] RTU_FC_RWMULT = 8'h17;
  localparam logic [7:0] RTU_EXC_FLAG = 8'h80;
  localparam logic [7:0] RTU_EXC_FUNC = 8'h01;
  localparam logic [7:0] RTU_EXC_ADDR = 8'h02;
  localparam logic [7:0] RTU_NODE_BCAST = 8'h00;
  localparam logic [7:0] RTU_NODE_MIN = 8'h01;
  localparam logic [7:0] RTU_NODE_MAX = 8'hf7;
  localparam logic [7:0] RTU_REQ_LEN = 8'h08;
  localparam logic [7:0] RTU_MIN_FRAME = 8'h04;
  localparam logic [15:0] RTU_RD_ABS_MAX = 16'h007d;
  localparam logic [15:0] RTU_CRC_SEED = 16'hffff;
  localparam logic [15:0] RTU_CRC_POLY = 16'ha001;
  localparam logic [14:0] RTU_STD_MULT = 15'h0064;
  localparam logic [14:0] RTU_STD_MENU_MAX = 15'h00a2;
  localparam logic [6:0] RTU_MOD_MENU_MAX = 7'h3f;
  localparam logic [1:0] RTU_TYPE_I16 = 2'h0;
  localparam logic [1:0] RTU_TYPE_I32 = 2'h1;
  localparam logic [1:0] RTU_TYPE_F32 = 2'h2;
  localparam logic [1:0] RTU_TYPE_RSVD = 2'h3;
  localparam logic [2:0] RTU_HDR_SHORT = 3'h3;
  localparam logic [2:0] RTU_HDR_ECHO = 3'h6;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_DEC = 8'h02,
    S_REQ = 8'h04,
    S_WAIT = 8'h08,
    S_HDR = 8'h10,
    S_DATA = 8'h20,
    S_CRCL = 8'h40,
    S_CRCH = 8'h80
  } rtu_state_e;

  typedef struct packed {
    logic ok;
    logic [1:0] dtype;
    logic [7:0] menu;
    logic [7:0] param;
  } rtu_map_s;

  // register address to menu/parameter, after the slave-side increment
  function automatic rtu_map_s rtu_map(input logic [15:0] raw, input logic modified);
    rtu_map_s m;
    logic [14:0] p;
    logic [14:0] menu_std;
    p = {1'b0, raw[13:0]} + 15'h0001;
    menu_std = p / RTU_STD_MULT;
    m.dtype = raw[15:14];
    if (modified) begin
      m.menu = {1'b0, p[14:8]};
      m.param = p[7:0];
      m.ok = (p[14:8] <= RTU_MOD_MENU_MAX);
    end else begin
      m.menu = menu_std[7:0];
      m.param = 8'(p - menu_std * RTU_STD_MULT);
      m.ok = (menu_std <= RTU_STD_MENU_MAX);
    end
    if (raw[15:14] == RTU_TYPE_RSVD) begin
      m.ok = 1'b0;
    end
    return m;
  endfunction : rtu_map

endpackage : rtu_pkg

// *** hw/rtu_crc16.sv ***
`timescale 1ns/1ps
module rtu_crc16
  import rtu_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  output logic [15:0] crc_o
);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  always_comb begin
    crc_next = crc_reg;
    if (clr_i) begin
      crc_next = RTU_CRC_SEED;
    end else if (en_i) begin
      crc_next = crc_reg ^ {8'h00, data_i};
      for (int i = 0; i < 8; i++) begin
        crc_next = crc_next[0] ? ((crc_next >> 1) ^ RTU_CRC_POLY) : (crc_next >> 1);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_reg <= RTU_CRC_SEED;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc_o = crc_reg;

endmodule : rtu_crc16

// *** hw/rtu_gap_timer.sv ***
`timescale 1ns/1ps
module rtu_gap_timer
  import rtu_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic rx_valid_i,
  input wire logic [19:0] char_cycles_i,
  output logic frame_end_o
);

  logic [21:0] thr;
  logic [21:0] cnt_reg;
  logic [21:0] cnt_next;
  logic armed_reg;
  logic armed_next;
  logic end_reg;
  logic end_next;

  // three and a half characters of silence
  assign thr = {1'b0, char_cycles_i, 1'b0} + {2'b00, char_cycles_i} + {3'b000, char_cycles_i[19:1]};

  always_comb begin
    cnt_next = cnt_reg;
    armed_next = armed_reg;
    end_next = 1'b0;
    if (rx_valid_i) begin
      cnt_next = '0;
      armed_next = 1'b1;
    end else if (armed_reg) begin
      if (cnt_reg + 22'h000001 >= thr) begin
        armed_next = 1'b0;
        end_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 22'h000001;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      armed_reg <= 1'b0;
      end_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      armed_reg <= armed_next;
      end_reg <= end_next;
    end
  end

  assign frame_end_o = end_reg;

endmodule : rtu_gap_timer

// *** verification/rtu_slave_asserts.sv ***
`timescale 1ns/1ps
module rtu_slave_asserts
  import rtu_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] node_addr_i,
  input wire logic addr_mode_i,
  input wire logic [19:0] char_cycles_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_two_stop_o,
  input wire logic par_req_o,
  input wire logic par_write_o,
  input wire logic [1:0] par_type_o,
  input wire logic [7:0] par_menu_o,
  input wire logic [7:0] par_param_o,
  input wire logic [15:0] par_wdata_o,
  input wire logic par_ack_i,
  input wire logic busy_o,
  input wire logic crc_err_o
);
  logic [20:0] gap_reg, gap_next, thr;
  logic in_rep_reg, in_rep_next;

  // silence since the last received byte saturates so a long idle never wraps
  always_comb begin
    thr = 21'(char_cycles_i) * 21'h3 + 21'(char_cycles_i >> 1);
    gap_next = rx_valid_i ? 21'h0 : gap_reg + {20'h0, ~&gap_reg};
    in_rep_next = busy_o & (in_rep_reg | (tx_valid_o & tx_ready_i));
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_reg <= 21'h0;
      in_rep_reg <= 1'b0;
    end else begin
      gap_reg <= gap_next;
      in_rep_reg <= in_rep_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_take;
    tx_valid_o && tx_ready_i;
  endsequence
  sequence s_stall;
    tx_valid_o && !tx_ready_i;
  endsequence
  sequence s_wait;
    par_req_o && !par_ack_i;
  endsequence

  stop_bits_a: assert property ($past(rst_n_i) |-> tx_two_stop_o)
    else $error("two stop bits not requested");
  tx_hold_a: assert property (s_stall |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed before taken");
  tx_gap_a: assert property (s_take |=> !tx_valid_o)
    else $error("no idle cycle after a taken byte");
  reply_addr_a: assert property (tx_valid_o && !in_rep_reg |-> tx_data_o == node_addr_i)
    else $error("reply does not open with own node address");
  req_hold_a: assert property (s_wait |=> par_req_o
    && $stable({par_write_o, par_type_o, par_menu_o, par_param_o, par_wdata_o}))
    else $error("parameter access changed before ack");
  type_rsvd_a: assert property (par_req_o |-> par_type_o != RTU_TYPE_RSVD)
    else $error("reserved type reached the parameter port");
  std_range_a: assert property (par_req_o && !addr_mode_i |-> par_menu_o <= 8'ha2 && par_param_o <= 8'h63)
    else $error("standard mapping out of range");
  mod_range_a: assert property (par_req_o && addr_mode_i |-> par_menu_o <= 8'h3f)
    else $error("modified mapping menu out of range");
  crc_drop_a: assert property (crc_err_o |=> (!crc_err_o && !par_req_o && !tx_valid_o)[*8])
    else $error("bad frame was acted on");
  silence_a: assert property (par_req_o || tx_valid_o |-> gap_reg >= thr)
    else $error("frame processed before line silence");
endmodule : rtu_slave_asserts

bind rtu_register_slave_decoder rtu_slave_asserts chk (
  .clock_i, .rst_n_i, .node_addr_i, .addr_mode_i, .char_cycles_i, .rx_valid_i, .tx_data_o,
  .tx_valid_o, .tx_ready_i, .tx_two_stop_o, .par_req_o, .par_write_o, .par_type_o, .par_menu_o,
  .par_param_o, .par_wdata_o, .par_ack_i, .busy_o, .crc_err_o
);

// *** verification/rtu_far_model.sv ***
`timescale 1ns/1ps
module rtu_far_model (
  input wire logic clock_i,
  input wire logic slow_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic par_req_i,
  input wire logic [7:0] par_menu_i,
  input wire logic [7:0] par_param_i,
  output logic par_ack_o,
  output logic [31:0] par_rdata_o
);
  logic [2:0] cnt;
  logic [1:0] hold;

  initial begin
    cnt = 3'h0;
    hold = 2'h0;
    tx_ready_o = 1'b0;
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    par_ack_o = 1'b0;
    par_rdata_o = 32'h0;
  end

  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction : crc

  // bad flips one check bit so the frame must be thrown away
  task automatic send(input logic [7:0] fr[$], input logic bad);
    logic [15:0] c;
    c = crc(fr) ^ {15'h0, bad};
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    foreach (fr[i]) begin
      @(negedge clock_i);
      rx_data_o = fr[i];
      rx_valid_o = 1'b1;
      @(negedge clock_i);
      rx_valid_o = 1'b0;
      rx_data_o = ~fr[i];
      repeat (8) @(negedge clock_i);
    end
  endtask : send

  ////////////////////////////////////////////////////////////////
  // slow mode stalls the reply three cycles in four and delays acks
  always @(posedge clock_i) begin
    cnt <= cnt + 3'h1;
    tx_ready_o <= !slow_i || cnt[1:0] == 2'h0;
    par_ack_o <= 1'b0;
    par_rdata_o <= ~par_rdata_o;
    if (hold != 2'h0) hold <= hold - 2'h1;
    if (par_req_i && !par_ack_o && hold == 2'h0 && (!slow_i || cnt[0])) begin
      par_ack_o <= 1'b1;
      hold <= 2'h3;
      par_rdata_o <= {par_menu_i, par_param_i, ~par_menu_i, par_param_i ^ 8'h3c};
    end
  end
endmodule : rtu_far_model

// *** verification/rtu_register_slave_decoder_bench.sv ***
`timescale 1ns/1ps
module rtu_register_slave_decoder_bench
  import rtu_pkg::*;
;
  logic clock_i, rst_n_i, addr_mode_i, rx_valid_i, tx_ready_i, slow;
  logic tx_valid_o, tx_two_stop_o, par_req_o, par_write_o, par_ack_i, busy_o, crc_err_o;
  logic [7:0] node_addr_i, rx_data_i, tx_data_o, par_menu_o, par_param_o;
  logic [1:0] par_type_o;
  logic [15:0] max_read_regs_i, par_wdata_o, wd;
  logic [19:0] char_cycles_i;
  logic [31:0] par_rdata_i;
  logic [7:0] texp[$], f[$], r[$];
  logic [7:0] codes[5] = '{8'h01, 8'h05, 8'h0f, RTU_FC_WMULT, RTU_FC_RWMULT};
  logic [34:0] pexp[$], g;
  int fail_count, n_compared, errs, seed, t;

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  rtu_register_slave_decoder uut (
    .clock_i, .rst_n_i, .node_addr_i, .addr_mode_i, .max_read_regs_i, .char_cycles_i,
    .rx_data_i, .rx_valid_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .tx_two_stop_o,
    .par_req_o, .par_write_o, .par_type_o, .par_menu_o, .par_param_o, .par_wdata_o,
    .par_ack_i, .par_rdata_i, .busy_o, .crc_err_o
  );
  rtu_far_model pm (
    .clock_i, .slow_i(slow), .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i),
    .rx_valid_o(rx_valid_i), .par_req_i(par_req_o), .par_menu_i(par_menu_o),
    .par_param_i(par_param_o), .par_ack_o(par_ack_i), .par_rdata_o(par_rdata_i)
  );

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [34:0] e, input logic [34:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic reply(input logic [7:0] q[$]);
    logic [15:0] c;
    c = pm.crc(q);
    texp = {texp, q, c[7:0], c[15:8]};
  endtask : reply

  // a queue left non-empty means a reply or an access went missing
  task automatic run(input logic bad);
    pm.send(f, bad);
    repeat (45) @(negedge clock_i);
    for (t = 0; t < 3000 && (busy_o !== 1'b0 || texp.size() > 0 || pexp.size() > 0); t++) @(negedge clock_i);
    if (t == 3000) begin
      fail_count++;
      results();
    end
    $display("test done, %0d compared so far", n_compared);
  endtask : run

  always @(posedge clock_i) begin
    if (crc_err_o === 1'b1) errs++;
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      chk("tx byte", texp.size() > 0 ? {27'h0, texp.pop_front()} : 35'h100, {27'h0, tx_data_o});
    if (par_req_o === 1'b1 && par_ack_i === 1'b1) begin
      g = {par_write_o, par_type_o, par_menu_o, par_param_o, par_write_o ? par_wdata_o : 16'h0};
      chk("access", pexp.size() > 0 ? pexp.pop_front() : ~g, g);
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h999b;
    rst_n_i = 1'b0;
    node_addr_i = 8'h05;
    addr_mode_i = 1'b0;
    max_read_regs_i = 16'h0004;
    char_cycles_i = 20'h0000a;
    slow = 1'b0;
    fail_count = 0;
    n_compared = 0;
    errs = 0;
    repeat (12) @(negedge clock_i);
    rst_n_i = 1'b1;
    for (int m = 0; m < 2; m++) begin
      addr_mode_i = m[0];
      slow = m[0];
      wd = 16'($random(seed));
      f = '{8'h05, RTU_FC_WRITE, m ? 8'h03 : 8'h00, m ? 8'ha0 : 8'h77, wd[15:8], wd[7:0]};
      pexp.push_back({1'b1, RTU_TYPE_I16, m ? 8'h03 : 8'h01, m ? 8'ha1 : 8'h14, wd});
      reply(f);
      run(1'b0);
    end
    f[0] = RTU_NODE_BCAST;
    pexp.push_back({1'b1, RTU_TYPE_I16, 8'h03, 8'ha1, wd});
    run(1'b0);
    f[0] = 8'h06;
    run(1'b0);
    node_addr_i = 8'hf8;
    f[0] = 8'hf8;
    run(1'b0);
    node_addr_i = 8'h05;
    f[0] = 8'h05;
    run(1'b1);
    chk("dropped frames", 35'h1, 35'(errs));
    addr_mode_i = 1'b0;
    for (int ty = 0; ty < 4; ty++) begin
      f = '{8'h05, RTU_FC_READ, {ty[1:0], 6'h00}, 8'h77, 8'h00, ty ? 8'h02 : 8'h01};
      if (ty == 3)
        reply('{8'h05, RTU_FC_READ | RTU_EXC_FLAG, RTU_EXC_ADDR});
      else begin
        pexp.push_back({1'b0, ty[1:0], 8'h01, 8'h14, 16'h0});
        if (ty == 0) reply('{8'h05, RTU_FC_READ, 8'h02, 8'hfe, 8'h28});
        else reply('{8'h05, RTU_FC_READ, 8'h04, 8'h01, 8'h14, 8'hfe, 8'h28});
      end
      run(1'b0);
    end
    slow = 1'b1;
    for (int n = 4; n < 6; n++) begin
      f = '{8'h05, RTU_FC_READ, 8'h00, 8'h77, 8'h00, 8'(n)};
      r = '{8'h05, RTU_FC_READ | RTU_EXC_FLAG, RTU_EXC_ADDR};
      if (n == 4) begin
        r = '{8'h05, RTU_FC_READ, 8'h08};
        for (int i = 0; i < 4; i++) begin
          pexp.push_back({1'b0, RTU_TYPE_I16, 8'h01, 8'h14 + 8'(i), 16'h0});
          r = {r, 8'hfe, (8'h14 + 8'(i)) ^ 8'h3c};
        end
      end
      reply(r);
      run(1'b0);
    end
    f = '{8'h05, RTU_FC_READ, 8'h40, 8'h77, 8'h00, 8'h03};
    reply('{8'h05, RTU_FC_READ | RTU_EXC_FLAG, RTU_EXC_ADDR});
    run(1'b0);
    // a read request one byte short is dropped without reply
    f = '{8'h05, RTU_FC_READ, 8'h00, 8'h77, 8'h00};
    run(1'b0);
    slow = 1'b0;
    foreach (codes[i]) begin
      f = '{8'h05, codes[i], 8'h00, 8'h77, 8'h00, 8'h01};
      if (i < 3) reply('{8'h05, codes[i] | RTU_EXC_FLAG, RTU_EXC_FUNC});
      run(1'b0);
    end
    f[0] = RTU_NODE_BCAST;
    f[1] = 8'h01;
    run(1'b0);
    chk("two stop bits", 35'h1, {34'h0, tx_two_stop_o});
    results();
  end
endmodule : rtu_register_slave_decoder_bench
